// *** hdl/xmb_ctrl.sv ***
/*
 * external memory bus configuration and access sequencer: two control
 * registers, pin override of the muxed address/data port, high address
 * port and strobes, sector decode with per-sector wait states, bus keeper.
 * assumes the cpu data path issues one access request a cycle at most,
 * holds it until acc_done, and that pins are synchronous to core_clk
 * except ad_in, which passes two flip-flops.
 */
`timescale 1ns/1ps
// What this block does
// - enable bit hands pins to the bus
// - enabled bus ignores port direction settings except on released high pins
// - cleared enable restores normal port pins
// - disabled bus never aliases onto internal ram
// - zero limit: one sector, upper waits
// - limit k: upper from k*0x2000 upward
// - bits 3..2 give upper sector waits
// - bits 1..0 give lower sector waits
// - wait codes: 0,1,2, 2 plus idle
// - keeper holds muxed lines when floating
// - keeper works with bus disabled too
// - reserved control b bits read zero
// - mask releases top high address pins
// - released pins act as port pins
// - internal addresses still appear on the address pins
// - external space starts past internal ram
// - internal access: no read/store strobe
// - address valid at latch fall, low meanwhile
// - trailing latch pulse only if next accesses
module xmb_ctrl #(
	parameter logic [15:0] RAM_END = xmb_pkg::XMB_DEF_RAM_END
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// register port
	input wire logic [0:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// cpu data access request
	input wire logic acc_req,
	input wire logic acc_write,
	input wire logic [15:0] acc_addr,
	input wire logic [7:0] acc_wdata,
	input wire logic acc_next_data,
	output logic acc_done,
	output logic [7:0] acc_rdata,
	// port settings for the muxed and high pins when not overridden
	input wire logic [7:0] lo_port_out,
	input wire logic [7:0] lo_port_dir,
	input wire logic [7:0] hi_port_out,
	input wire logic [7:0] hi_port_dir,
	// muxed address/data pins (oe low drives)
	input wire logic [7:0] ad_in,
	output logic [7:0] ad_out,
	output logic [7:0] ad_oe_n,
	// high address pins (oe low drives)
	output logic [7:0] ha_out,
	output logic [7:0] ha_oe_n,
	// strobes, high active latch, low active read and store
	output logic latch_strobe,
	output logic rd_strobe_n,
	output logic wr_strobe_n,
	output logic keeper_on
);
	import xmb_pkg::*;

	initial begin
		if (RAM_END == 16'h0000 || RAM_END >= 16'hFF00) begin
			$error("xmb_ctrl: RAM_END out of range");
		end
	end

	// whole state of the block
	typedef struct packed {
		logic [7:0] ctrl_a;   // control register a
		logic [7:0] ctrl_b;   // control register b, reserved bits zero
		logic [7:0] rdata;    // register read data
		xmb_state_t st;       // access sequencer state
		logic [1:0] wcnt;     // wait cycles left
		logic [1:0] wcode;    // wait code of current access
		logic is_ext;         // current access goes off chip
		logic wr;             // current access is a store
		logic [15:0] addr;    // captured address
		logic [7:0] wdata;    // captured store data
		logic [7:0] ad_out;
		logic [7:0] ad_oe_n;
		logic [7:0] ha_out;
		logic [7:0] ha_oe_n;
		logic ale;
		logic rd_n;
		logic wr_n;
		logic done;
		logic [7:0] acc_rdata;
		logic keeper;
		logic [7:0] ad_s1;    // synchroniser first stage
		logic [7:0] ad_s2;    // synchroniser second stage
	} xmb_regs_t;

	xmb_regs_t r;
	xmb_regs_t next_r;

	// decoded configuration
	logic bus_en;
	logic [2:0] sec_limit;
	logic [2:0] hi_mask;
	logic [7:0] hi_release;
	logic sel_upper;
	logic [1:0] sel_code;
	logic addr_ext;

	assign bus_en = r.ctrl_a[XMB_A_ENABLE];
	assign sec_limit = r.ctrl_a[XMB_A_SRL_LO +: 3];
	assign hi_mask = r.ctrl_b[XMB_B_MASK_LO +: 3];

	// pins released from the high address byte, top pins first
	always_comb begin
		unique case (hi_mask)
			3'h0: hi_release = 8'h00;
			3'h1: hi_release = 8'h80;
			3'h2: hi_release = 8'hC0;
			3'h3: hi_release = 8'hE0;
			3'h4: hi_release = 8'hF0;
			3'h5: hi_release = 8'hF8;
			3'h6: hi_release = 8'hFC;
			3'h7: hi_release = 8'hFF;
		endcase
	end

	// sector decode from the top three address bits against the limit
	assign sel_upper = (sec_limit == 3'h0) || (acc_addr[15:13] >= sec_limit);
	assign sel_code = sel_upper ? r.ctrl_a[XMB_A_UWAIT_LO +: 2] :
		r.ctrl_a[XMB_A_LWAIT_LO +: 2];
	// external only above internal ram and only with the bus on
	assign addr_ext = bus_en && (acc_addr > RAM_END);

	// next state
	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		next_r.ad_s1 = ad_in;
		next_r.ad_s2 = r.ad_s1;
		next_r.keeper = r.ctrl_b[XMB_B_KEEPER];

		// register writes, reserved bits of b forced to zero
		if (reg_wr) begin
			if (reg_addr == XMB_OFS_CTRL_A) begin
				next_r.ctrl_a = reg_wdata;
			end else begin
				next_r.ctrl_b = reg_wdata & XMB_B_WRITE_MASK;
			end
		end
		// register reads answer next cycle
		if (reg_rd) begin
			next_r.rdata = (reg_addr == XMB_OFS_CTRL_A) ? r.ctrl_a : r.ctrl_b;
		end else begin
			next_r.rdata = 8'h00;
		end

		// access sequencer
		unique case (r.st)
			XMB_IDLE: begin
				next_r.ale = 1'b0;
				// a done pulse means the cpu still holds the finished
				// request, so taking it again would repeat the access
				if (acc_req && !r.done) begin
					next_r.is_ext = addr_ext;
					next_r.wr = acc_write;
					next_r.addr = acc_addr;
					next_r.wdata = acc_write ? acc_wdata : 8'h00;
					next_r.wcode = sel_code;
					next_r.wcnt = (sel_code == XMB_WAIT_NONE) ? 2'h0 :
						((sel_code == XMB_WAIT_ONE) ? 2'h1 : 2'h2);
					// address phase: latch high, low address on the bus
					next_r.ale = bus_en;
					next_r.st = XMB_ADDR;
				end
			end
			XMB_ADDR: begin
				// latch falls with the address still valid
				next_r.ale = 1'b0;
				next_r.st = XMB_STROBE;
				if (r.is_ext) begin
					next_r.rd_n = r.wr;
					next_r.wr_n = ~r.wr;
				end
			end
			XMB_STROBE: begin
				if (r.wcnt != 2'h0) begin
					next_r.wcnt = r.wcnt - 2'h1;
					next_r.st = XMB_STROBE;
				end else begin
					// last strobe cycle: release both strobes
					next_r.rd_n = 1'b1;
					next_r.wr_n = 1'b1;
					next_r.st = XMB_WAIT;
				end
			end
			XMB_WAIT: begin
				// the pin synchroniser needs this cycle before the last
				// strobe-time sample of a load reaches its second stage
				next_r.st = XMB_TAIL;
			end
			XMB_TAIL: begin
				next_r.rd_n = 1'b1;
				next_r.wr_n = 1'b1;
				next_r.done = 1'b1;
				next_r.acc_rdata = (r.is_ext && !r.wr) ? r.ad_s2 : 8'h00;
				next_r.ale = bus_en && acc_next_data && r.wcode != XMB_WAIT_TWO_IDLE;
				next_r.st = (r.wcode == XMB_WAIT_TWO_IDLE) ? XMB_GAP : XMB_IDLE;
			end
			XMB_GAP: begin
				// idle cycle before a new address is driven
				next_r.ale = bus_en && acc_next_data;
				next_r.st = XMB_IDLE;
			end
			default: begin
				next_r.st = XMB_IDLE;
			end
		endcase

		// muxed pins: address, then store data or released for read
		if (bus_en) begin
			if (next_r.st == XMB_ADDR) begin
				next_r.ad_out = next_r.addr[7:0];
				next_r.ad_oe_n = 8'h00;
			end else if (next_r.st == XMB_STROBE && next_r.wr) begin
				next_r.ad_out = next_r.wdata;
				next_r.ad_oe_n = 8'h00;
			end else if (next_r.st == XMB_STROBE || next_r.st == XMB_TAIL) begin
				next_r.ad_out = 8'h00;
				next_r.ad_oe_n = 8'hFF;
			end else begin
				next_r.ad_out = r.ad_out;
				next_r.ad_oe_n = 8'hFF;
			end
			// high pins: masked ones return to port control
			next_r.ha_out = (next_r.addr[15:8] & ~hi_release) |
				(hi_port_out & hi_release);
			// address pins always drive, released ones follow the port
			next_r.ha_oe_n = hi_release & ~hi_port_dir;
		end else begin
			// plain port behaviour
			next_r.ad_out = lo_port_out;
			next_r.ad_oe_n = ~lo_port_dir;
			next_r.ha_out = hi_port_out;
			next_r.ha_oe_n = ~hi_port_dir;
			next_r.ale = 1'b0;
			next_r.rd_n = 1'b1;
			next_r.wr_n = 1'b1;
		end

		if (rst) begin
			next_r = '0;
			next_r.ctrl_a = XMB_RST_CTRL_A;
			next_r.ctrl_b = XMB_RST_CTRL_B;
			next_r.st = XMB_IDLE;
			next_r.rd_n = 1'b1;
			next_r.wr_n = 1'b1;
			next_r.ad_oe_n = 8'hFF;
			next_r.ha_oe_n = 8'hFF;
		end
	end

	// one register bank for all state
	always_ff @(posedge core_clk) begin
		r <= next_r;
	end

	// outputs straight from flip-flops
	assign reg_rdata = r.rdata;
	assign acc_done = r.done;
	assign acc_rdata = r.acc_rdata;
	assign ad_out = r.ad_out;
	assign ad_oe_n = r.ad_oe_n;
	assign ha_out = r.ha_out;
	assign ha_oe_n = r.ha_oe_n;
	assign latch_strobe = r.ale;
	assign rd_strobe_n = r.rd_n;
	assign wr_strobe_n = r.wr_n;
	assign keeper_on = r.keeper;

	// strobes never move for internal accesses
	chk_internal_quiet: assert property (@(posedge core_clk) disable iff (rst)
		(r.st == XMB_STROBE && !r.is_ext) |-> (rd_strobe_n && wr_strobe_n))
		else $error("strobe active on internal access");

	// disabled bus leaves pins to the port
	chk_disabled_port: assert property (@(posedge core_clk) disable iff (rst)
		$past(!bus_en && !rst) |-> (ha_out == $past(hi_port_out)))
		else $error("high pins not under port control");

	// reserved bits of b always zero
	chk_reserved_zero: assert property (@(posedge core_clk) disable iff (rst)
		r.ctrl_b[6:3] == 4'h0)
		else $error("reserved control bits set");

	// keeper follows its bit one cycle later, bus state irrelevant
	chk_keeper_follow: assert property (@(posedge core_clk) disable iff (rst)
		##1 keeper_on == $past(r.ctrl_b[XMB_B_KEEPER]))
		else $error("keeper does not follow its bit");

	// no wait code: strobe lasts one cycle, then released
	chk_nowait_len: assert property (@(posedge core_clk) disable iff (rst)
		(r.st == XMB_ADDR && r.is_ext && r.wcode == XMB_WAIT_NONE)
		|=> (!rd_strobe_n || !wr_strobe_n) ##1 (rd_strobe_n && wr_strobe_n))
		else $error("zero wait strobe length wrong");

	// two waits: strobe held three cycles
	chk_twowait_len: assert property (@(posedge core_clk) disable iff (rst)
		(r.st == XMB_ADDR && r.is_ext && r.wcode == XMB_WAIT_TWO)
		|=> (!rd_strobe_n || !wr_strobe_n) [*3] ##1 (rd_strobe_n && wr_strobe_n))
		else $error("two wait strobe length wrong");

	// latch low while the strobe is active
	chk_latch_low: assert property (@(posedge core_clk) disable iff (rst)
		(!rd_strobe_n || !wr_strobe_n) |-> !latch_strobe)
		else $error("latch high during transfer");

	// zero limit uses the upper wait setting
	chk_one_sector: assert property (@(posedge core_clk) disable iff (rst)
		(r.st == XMB_IDLE && acc_req && !r.done && sec_limit == 3'h0)
		|=> r.wcode == $past(r.ctrl_a[3:2]))
		else $error("single sector wait code wrong");

	// internal addresses stay internal
	chk_internal_addr: assert property (@(posedge core_clk) disable iff (rst)
		(r.st == XMB_IDLE && acc_req && !r.done && acc_addr <= RAM_END) |=> !r.is_ext)
		else $error("internal address marked external");

	// lower sector takes the lower wait setting
	chk_lower_sector: assert property (@(posedge core_clk) disable iff (rst)
		(r.st == XMB_IDLE && acc_req && !r.done && sec_limit != 3'h0 &&
		acc_addr[15:13] < sec_limit) |=> r.wcode == $past(r.ctrl_a[1:0]))
		else $error("lower sector wait code wrong");

	// code three adds one idle cycle after the tail
	chk_idle_gap: assert property (@(posedge core_clk) disable iff (rst)
		(r.st == XMB_TAIL && r.wcode == XMB_WAIT_TWO_IDLE) |=> r.st == XMB_GAP)
		else $error("idle cycle missing after code three access");
endmodule // xmb_ctrl

// *** hdl/xmb_pkg.sv ***
/*
 * constants for the external memory bus configuration block: register
 * offsets on the plain register port, field positions, reset values and
 * the memory map figures.
 * assumes a single core clock and nothing else from its surroundings.
 */
package xmb_pkg;
	// register offsets on the plain register port
	localparam logic [0:0] XMB_OFS_CTRL_A = 1'h0;
	localparam logic [0:0] XMB_OFS_CTRL_B = 1'h1;
	// reset values
	localparam logic [7:0] XMB_RST_CTRL_A = 8'h00;
	localparam logic [7:0] XMB_RST_CTRL_B = 8'h00;
	// control register a fields
	localparam int XMB_A_ENABLE = 7;
	localparam int XMB_A_SRL_LO = 4;
	localparam int XMB_A_UWAIT_LO = 2;
	localparam int XMB_A_LWAIT_LO = 0;
	// control register b fields
	localparam int XMB_B_KEEPER = 7;
	localparam int XMB_B_MASK_LO = 0;
	localparam logic [7:0] XMB_B_WRITE_MASK = 8'h87;
	// memory map
	localparam logic [15:0] XMB_SECTOR_STEP = 16'h2000;
	localparam logic [15:0] XMB_TOP_ADDR = 16'hFFFF;
	localparam logic [15:0] XMB_DEF_RAM_END = 16'h10FF;
	// wait codes
	localparam logic [1:0] XMB_WAIT_NONE = 2'h0;
	localparam logic [1:0] XMB_WAIT_ONE = 2'h1;
	localparam logic [1:0] XMB_WAIT_TWO = 2'h2;
	localparam logic [1:0] XMB_WAIT_TWO_IDLE = 2'h3;
	// access cycle states
	typedef enum logic [2:0] {
		XMB_IDLE, XMB_ADDR, XMB_STROBE, XMB_WAIT, XMB_TAIL, XMB_GAP
	} xmb_state_t;
endpackage : xmb_pkg

// *** test/xmb_sram_model.sv ***
/*
 * sram model behind an address latch, on the far side of the memory bus.
 * assumes the block's pin outputs and core_clk; a 32 KB part, top address bit unwired.
 */
`timescale 1ns/1ps
module xmb_sram_model (
	// clock
	input wire logic core_clk,
	// pins of the block
	input wire logic [7:0] ad_out,
	input wire logic [7:0] ha_out,
	input wire logic latch_strobe,
	input wire logic rd_strobe_n,
	input wire logic wr_strobe_n,
	output logic [7:0] ad_in
);
	logic [7:0] mem [0:32767]; // 32 KB part
	logic [7:0] lo_lat = 8'h00; // octal latch contents
	logic [7:0] last = 8'h00; // last byte driven
	int hold = 0; // cycles the data stays after the read strobe
	// top bit unwired, so the upper half aliases onto the lower
	wire [14:0] addr = {ha_out[6:0], lo_lat};
	// latch, store and read timing
	always @(posedge core_clk) begin
		if (latch_strobe) begin
			lo_lat <= ad_out;
		end
		if (!wr_strobe_n) begin
			mem[addr] <= ad_out;
		end
		if (!rd_strobe_n) begin
			last <= mem[addr];
			hold <= 3;
		end else if (hold > 0) begin
			hold <= hold - 1;
		end
	end
	// a released bus shows the inverse, so stale data never passes for good data
	assign ad_in = !rd_strobe_n ? mem[addr] : (hold > 0 ? last : ~last);
endmodule // xmb_sram_model

// *** test/test_external_memory_bus_config.sv ***
/*
 * self-checking bench for the external memory bus block with an sram model.
 * assumes xmb_pkg, xmb_ctrl and xmb_sram_model are compiled first.
 */
`timescale 1ns/1ps
module test_external_memory_bus_config;
	import xmb_pkg::*;
	// expected load data, strobe-low cycles, latch check flag and level
	typedef struct {logic [7:0] d; int s; logic [1:0] l;} xmb_note_t;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [0:0] reg_addr = 1'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic acc_req = 1'b0;
	logic acc_write = 1'b0;
	logic [15:0] acc_addr = 16'h0000;
	logic [7:0] acc_wdata = 8'h00;
	logic acc_next_data = 1'b0;
	logic [7:0] lo_port_out = 8'h00;
	logic [7:0] lo_port_dir = 8'h00;
	logic [7:0] hi_port_out = 8'h00;
	logic [7:0] hi_port_dir = 8'h00;
	wire [7:0] reg_rdata, acc_rdata, ad_in, ad_out, ad_oe_n, ha_out, ha_oe_n;
	wire acc_done, latch_strobe, rd_strobe_n, wr_strobe_n, keeper_on;
	int n_mismatch = 0;
	int num_checks = 0;
	int cycles = 0; // hang guard
	int lows = 0; // strobe-low cycles of the running access
	integer seed = 16;
	logic rd_d = 1'b0; // a read was issued last cycle
	logic [7:0] rel; // released high pins
	logic [7:0] reg_q[$];
	xmb_note_t acc_q[$];

	xmb_ctrl xmb_ctrl_inst (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .acc_req, .acc_write, .acc_addr, .acc_wdata, .acc_next_data, .acc_done,
		.acc_rdata, .lo_port_out, .lo_port_dir, .hi_port_out, .hi_port_dir, .ad_in, .ad_out,
		.ad_oe_n, .ha_out, .ha_oe_n, .latch_strobe, .rd_strobe_n, .wr_strobe_n, .keeper_on);
	xmb_sram_model xmb_sram_model_inst (.core_clk, .ad_out, .ha_out, .latch_strobe,
		.rd_strobe_n, .wr_strobe_n, .ad_in);

	// free-running core clock
	initial begin
		forever #5 core_clk = ~core_clk;
	end

	function automatic logic [7:0] rnd8();
		return 8'($random(seed));
	endfunction

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic complete_run;
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// register read or write; the extra edge keeps strobes apart
	task automatic reg_op(input logic rd, input logic [0:0] a, input logic [7:0] d);
		if (rd) begin
			reg_q.push_back(d);
		end
		reg_addr <= a;
		reg_wdata <= d;
		reg_rd <= rd;
		reg_wr <= !rd;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask

	// one cpu access; c is the wait code of its sector, ext marks an external one
	task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d,
		input logic [7:0] e, input int c, input logic ext);
		int n;
		int wt;
		logic [7:0] r;
		n = 0;
		wt = (c == 3) ? 2 : c; // code 3 waits two plus an idle gap
		r = rnd8();
		acc_req <= 1'b1;
		acc_write <= w;
		acc_addr <= a;
		acc_wdata <= d;
		acc_next_data <= r[0];
		acc_q.push_back('{e, ext ? 1 + wt : 0, {ext && c != 3, r[0]}});
		do begin
			@(posedge core_clk);
			n++;
		end while (acc_done !== 1'b1 && n < 50);
		check("acc_done", {7'h00, acc_done}, 8'h01);
		if (ext) begin
			check("latency", 8'(n), 8'(6 + wt));
		end
		acc_req <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask

	// hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			complete_run();
		end
	end

	// read answers and access results against the oldest note
	always @(posedge core_clk) begin
		xmb_note_t n;
		rd_d <= reg_rd;
		if (rd_d) begin
			check("reg_rdata", reg_rdata, reg_q.pop_front());
		end
		if (acc_done === 1'b1) begin
			n = acc_q.pop_front();
			check("acc_rdata", acc_rdata, n.d);
			check("strobe cycles", 8'(lows), 8'(n.s));
			if (n.l[1]) begin
				check("trailing latch", {7'h00, latch_strobe}, {7'h00, n.l[0]});
			end
			lows = 0;
		end else if (!rst && (rd_strobe_n !== 1'b1 || wr_strobe_n !== 1'b1)) begin
			lows++;
			check("latch in strobe", {7'h00, latch_strobe}, 8'h00);
		end
	end

	// main sequence
	initial begin
		logic [7:0] r;
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		// reset values, reserved bits of control b, keeper with the bus off
		reg_op(1'b1, XMB_OFS_CTRL_A, XMB_RST_CTRL_A);
		reg_op(1'b1, XMB_OFS_CTRL_B, XMB_RST_CTRL_B);
		r = rnd8() | 8'h80;
		reg_op(1'b0, XMB_OFS_CTRL_B, r);
		reg_op(1'b1, XMB_OFS_CTRL_B, r & XMB_B_WRITE_MASK);
		check("keeper_on", {7'h00, keeper_on}, 8'h01);
		hi_port_dir <= rnd8();
		hi_port_out <= rnd8();
		lo_port_dir <= rnd8();
		lo_port_out <= rnd8();
		reg_op(1'b0, XMB_OFS_CTRL_B, 8'h00);
		@(posedge core_clk);
		check("keeper_on", {7'h00, keeper_on}, 8'h00);
		check("ha_oe_n", ha_oe_n, ~hi_port_dir);
		check("ha_out", ha_out, hi_port_out);
		access(1'b0, 16'h4000, 8'h00, 8'h00, 0, 1'b0);
		// both sectors at their shared boundary, every wait code
		for (int c = 0; c < 4; c++) begin
			reg_op(1'b0, XMB_OFS_CTRL_A, 8'hB0 | 8'(c << 2) | 8'(3 - c));
			r = rnd8();
			access(1'b1, 16'h6000, r, 8'h00, c, 1'b1);
			access(1'b0, 16'h6000, 8'h00, r, c, 1'b1);
			access(1'b1, 16'h5FFF, ~r, 8'h00, 3 - c, 1'b1);
			access(1'b0, 16'h5FFF, 8'h00, ~r, 3 - c, 1'b1);
		end
		// limit zero: one sector on upper code 2, lower code 1 unused
		reg_op(1'b0, XMB_OFS_CTRL_A, 8'h89);
		access(1'b1, 16'h1100, r, 8'h00, 2, 1'b1);
		access(1'b0, XMB_DEF_RAM_END, 8'h00, 8'h00, 2, 1'b0);
		// released high pins follow the port, the others stay driven
		for (int m = 0; m < 8; m++) begin
			reg_op(1'b0, XMB_OFS_CTRL_B, 8'(m));
			@(posedge core_clk);
			rel = ~(8'hFF >> ((m == 7) ? 8 : m));
			check("ha_oe_n", ha_oe_n, ~hi_port_dir & rel);
			check("ha_out", ha_out & rel, hi_port_out & rel);
			check("ha_addr", ha_out & ~rel, XMB_DEF_RAM_END[15:8] & ~rel);
		end
		// masked top bits reach the low part of the sram, its alias too
		hi_port_out <= 8'h00;
		hi_port_dir <= 8'hFF;
		reg_op(1'b0, XMB_OFS_CTRL_A, 8'h80);
		reg_op(1'b0, XMB_OFS_CTRL_B, 8'h03);
		access(1'b1, 16'h2001, 8'hAA, 8'h00, 0, 1'b1);
		reg_op(1'b0, XMB_OFS_CTRL_B, 8'h00);
		access(1'b1, 16'h2001, 8'h55, 8'h00, 0, 1'b1);
		access(1'b0, 16'h8001, 8'h00, 8'hAA, 0, 1'b1);
		access(1'b0, 16'h2001, 8'h00, 8'h55, 0, 1'b1);
		// every noted access must have finished
		check("pending", 8'(acc_q.size()), 8'h00);
		complete_run();
	end
endmodule // test_external_memory_bus_config
